/* File: shared/hbrp_cfg.svh */
// Timing counts, widths, register window and strap levels of the host read port
`ifndef HBRP_CFG_SVH
`define HBRP_CFG_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define HBRP_ADDR_W         16
`define HBRP_DATA_W         16
`define HBRP_REG_AW         5
`define HBRP_RAM_AW_DEF     12
`define HBRP_AGE_W          8

// ****************************************************************
// Timing, in picoseconds, and derived cycle counts
// ****************************************************************
`define HBRP_CLK_PERIOD_PS  10000
`define HBRP_RAM_DONE_PS    437500
`define HBRP_REG_DONE_PS    187500
`define HBRP_RAM_DONE_CYC   ((`HBRP_RAM_DONE_PS + `HBRP_CLK_PERIOD_PS - 1) / `HBRP_CLK_PERIOD_PS)
`define HBRP_REG_DONE_CYC   ((`HBRP_REG_DONE_PS + `HBRP_CLK_PERIOD_PS - 1) / `HBRP_CLK_PERIOD_PS)

// ****************************************************************
// Register window with a floating data bus
// ****************************************************************
`define HBRP_HIDE_LO        5'h18
`define HBRP_HIDE_HI        5'h1f

// ****************************************************************
// Strap levels for the buffered 16-bit mode
// ****************************************************************
`define HBRP_BUS_STYLE_REQ  1'b0
`define HBRP_WIDTH_REQ      1'b1
`define HBRP_ZWAIT_REQ      1'b1

`endif

/* File: shared/hbrp_pkg.sv */
// Types of the host read port
package hbrp_pkg;
  `include "hbrp_cfg.svh"

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_SEL   = 6'h02,
    ST_PEND  = 6'h04,
    ST_GRANT = 6'h08,
    ST_DONE  = 6'h10,
    ST_HIGH  = 6'h20
  } hbrp_state_t;

  typedef struct packed {
    hbrp_state_t                state;
    logic [`HBRP_AGE_W-1:0]     age;
    logic                       skew;
    logic                       extra;
    logic                       ctrl_mem;
    logic                       ctrl_rd;
    logic [`HBRP_ADDR_W-1:0]    addr;
    logic [`HBRP_DATA_W-1:0]    data;
    logic                       oe;
    logic                       grant_n;
    logic                       done_n;
    logic                       ram_rd;
    logic                       reg_rd;
    logic                       rd_wait;
    logic                       prev_sel_n;
    logic                       prev_strb_n;
  } hbrp_st_t;
endpackage

/* File: shared/hbrp_pin_if.sv */
// Synchronised host pins passed from the synchroniser to the port logic
interface hbrp_pin_if;
  logic        sel_n;
  logic        strb_n;
  logic        mem_reg;
  logic        rd_wr;
  logic [15:0] addr;
  logic        pol;
  logic        late;
  logic        hide;
  logic        bus_style;
  logic        width;
  logic        zero_wait;

  modport drv (output sel_n, strb_n, mem_reg, rd_wr, addr, pol, late, hide,
               bus_style, width, zero_wait);
  modport sink (input sel_n, strb_n, mem_reg, rd_wr, addr, pol, late, hide,
                bus_style, width, zero_wait);
endinterface

/* File: core/hbrp_sync.sv */
// Two-stage synchroniser for every host pin and strap
module hbrp_sync (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // Raw host pins
  input  wire logic        sel_n_i,
  input  wire logic        strb_n_i,
  input  wire logic        mem_reg_i,
  input  wire logic        rd_wr_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        pol_i,
  input  wire logic        late_i,
  input  wire logic        hide_i,
  input  wire logic        bus_style_i,
  input  wire logic        width_i,
  input  wire logic        zero_wait_i,
  // Synchronised copies
  hbrp_pin_if.drv          pin
);
  localparam int W = 26;

  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } hbrp_sync_st_t;

  hbrp_sync_st_t st_reg;
  hbrp_sync_st_t st_next;
  logic [W-1:0]  raw;

  assign raw = {sel_n_i, strb_n_i, mem_reg_i, rd_wr_i, addr_i, pol_i, late_i,
                hide_i, bus_style_i, width_i, zero_wait_i};

  // First stage is read by the second stage only
  always_comb
  begin
    st_next = st_reg;
    if (ce_i)
    begin
      st_next.s1 = raw;
      st_next.s2 = st_reg.s1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_reg <= '{s2: {2'h3, 24'h000000}, s1: {2'h3, 24'h000000}};
    else
      st_reg <= st_next;
  end

  assign {pin.sel_n, pin.strb_n, pin.mem_reg, pin.rd_wr, pin.addr, pin.pol, pin.late,
          pin.hide, pin.bus_style, pin.width, pin.zero_wait} = st_reg.s2;
endmodule

/* File: core/hbrp_port.sv */
// Buffered non-zero-wait host read port: grant, latch, read and ready
`include "hbrp_cfg.svh"
// ****************************************************************
// ****************************************************************
module hbrp_port
  import hbrp_pkg::*;
#(
  parameter int RAM_AW = `HBRP_RAM_AW_DEF
) (
  // Clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  // Host control pins
  input  wire logic              host_sel_n_i,
  input  wire logic              host_strobe_n_i,
  input  wire logic              host_mem_reg_i,
  input  wire logic              host_rd_wr_i,
  input  wire logic [15:0]       host_addr_i,
  // Straps
  input  wire logic              polarity_strap_i,
  input  wire logic              late_sel_strap_i,
  input  wire logic              hide_regs_strap_i,
  input  wire logic              bus_style_strap_i,
  input  wire logic              width_strap_i,
  input  wire logic              zero_wait_strap_i,
  // Host answer pins
  output logic                   io_grant_n_o,
  output logic                   cycle_done_n_o,
  output logic [15:0]            host_data_o,
  output logic                   host_data_oe_o,
  // Internal RAM side
  input  wire logic              ram_busy_i,
  output logic                   ram_rd_o,
  output logic [RAM_AW-1:0]      ram_addr_o,
  input  wire logic [15:0]       ram_rd_data_i,
  // Internal register side
  output logic                   reg_rd_o,
  output logic [4:0]             reg_addr_o,
  input  wire logic [15:0]       reg_rd_data_i
);

  // ****************************************************************
  // Reset release and synchronised pins
  // ****************************************************************
  logic       rst_s1;
  logic       rst_q;
  hbrp_pin_if pin ();

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1 <= 1'b0;
      rst_q  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_q  <= rst_s1;
    end
  end

  hbrp_sync u_sync (
    .clk_i       (clk_i),
    .rst_n_i     (rst_q),
    .ce_i        (ce_i),
    .sel_n_i     (host_sel_n_i),
    .strb_n_i    (host_strobe_n_i),
    .mem_reg_i   (host_mem_reg_i),
    .rd_wr_i     (host_rd_wr_i),
    .addr_i      (host_addr_i),
    .pol_i       (polarity_strap_i),
    .late_i      (late_sel_strap_i),
    .hide_i      (hide_regs_strap_i),
    .bus_style_i (bus_style_strap_i),
    .width_i     (width_strap_i),
    .zero_wait_i (zero_wait_strap_i),
    .pin         (pin)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic is_read(input logic rd_wr, input logic pol);
    is_read = pol ? rd_wr : !rd_wr;
  endfunction

  function automatic logic in_hidden(input logic [4:0] a);
    in_hidden = (a >= `HBRP_HIDE_LO) && (a <= `HBRP_HIDE_HI);
  endfunction

  function automatic logic [`HBRP_AGE_W-1:0] done_age(input logic mem, input logic extra);
    logic [`HBRP_AGE_W-1:0] n;
    n = mem ? `HBRP_AGE_W'(`HBRP_RAM_DONE_CYC) : `HBRP_AGE_W'(`HBRP_REG_DONE_CYC);
    done_age = n - `HBRP_AGE_W'(1) + {{(`HBRP_AGE_W-1){1'b0}}, extra};
  endfunction

  // ****************************************************************
  // Port sequencer
  // ****************************************************************
  hbrp_st_t st_reg;
  hbrp_st_t st_next;
  logic     sel_low;
  logic     strb_low;
  logic     cfg_ok;
  logic     mem_now;
  logic     rd_now;

  assign sel_low  = !pin.sel_n;
  assign strb_low = !pin.strb_n;
  assign cfg_ok   = (pin.bus_style == `HBRP_BUS_STYLE_REQ) && (pin.width == `HBRP_WIDTH_REQ)
                    && (pin.zero_wait == `HBRP_ZWAIT_REQ);
  assign mem_now  = (st_reg.age == '0) ? pin.mem_reg : st_reg.ctrl_mem;
  assign rd_now   = (st_reg.age == '0) ? is_read(pin.rd_wr, pin.pol) : st_reg.ctrl_rd;

  always_comb
  begin
    st_next        = st_reg;
    st_next.ram_rd = 1'b0;
    st_next.reg_rd = 1'b0;
    if (ce_i)
    begin
      st_next.prev_sel_n  = pin.sel_n;
      st_next.prev_strb_n = pin.strb_n;
      st_next.rd_wait     = st_reg.ram_rd | st_reg.reg_rd;
      case (st_reg.state)
        ST_IDLE:
        begin
          if (strb_low && cfg_ok)
          begin
            if (pin.late)
              st_next.state = ST_SEL;
            else if (sel_low)
            begin
              st_next.skew  = st_reg.prev_sel_n != st_reg.prev_strb_n;
              st_next.state = ST_PEND;
              if (!ram_busy_i)
              begin
                st_next.grant_n = 1'b0;
                st_next.age     = '0;
                st_next.extra   = st_reg.prev_sel_n != st_reg.prev_strb_n;
                st_next.state   = ST_GRANT;
              end
            end
          end
        end
        ST_SEL:
        begin
          st_next.skew = 1'b0;
          if (!sel_low)
            st_next.state = ST_HIGH;
          else if (!ram_busy_i)
          begin
            st_next.grant_n = 1'b0;
            st_next.age     = '0;
            st_next.extra   = 1'b0;
            st_next.state   = ST_GRANT;
          end
          else
            st_next.state = ST_PEND;
        end
        ST_PEND:
        begin
          if (!strb_low)
            st_next.state = ST_IDLE;
          else if (!ram_busy_i && (pin.late || sel_low))
          begin
            st_next.grant_n = 1'b0;
            st_next.age     = '0;
            st_next.extra   = st_reg.skew && !pin.late;
            st_next.state   = ST_GRANT;
          end
        end
        ST_GRANT:
        begin
          // Select is ignored from here on
          st_next.age = st_reg.age + `HBRP_AGE_W'(1);
          if (st_reg.age == '0)
          begin
            st_next.ctrl_mem = pin.mem_reg;
            st_next.ctrl_rd  = is_read(pin.rd_wr, pin.pol);
          end
          if (st_reg.age == `HBRP_AGE_W'(st_reg.extra))
          begin
            st_next.addr = pin.addr;
            if (rd_now)
            begin
              st_next.ram_rd = mem_now;
              st_next.reg_rd = !mem_now;
            end
          end
          if (st_reg.rd_wait)
          begin
            st_next.data = st_reg.ctrl_mem ? ram_rd_data_i : reg_rd_data_i;
            st_next.oe   = st_reg.ctrl_mem || !pin.hide
                           || !in_hidden(st_reg.addr[4:0]);
          end
          if (!strb_low)
          begin
            st_next.grant_n = 1'b1;
            st_next.oe      = 1'b0;
            st_next.state   = ST_IDLE;
          end
          else if (st_reg.age == done_age(st_reg.ctrl_mem, st_reg.extra))
          begin
            st_next.done_n = 1'b0;
            st_next.state  = ST_DONE;
          end
        end
        ST_DONE:
        begin
          if (!strb_low)
          begin
            st_next.grant_n = 1'b1;
            st_next.done_n  = 1'b1;
            st_next.oe      = 1'b0;
            st_next.state   = ST_IDLE;
          end
        end
        ST_HIGH:
        begin
          if (!strb_low)
            st_next.state = ST_IDLE;
        end
        default:
        begin
          st_next.state   = ST_IDLE;
          st_next.grant_n = 1'b1;
          st_next.done_n  = 1'b1;
          st_next.oe      = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_q)
  begin
    if (!rst_q)
    begin
      st_reg             <= '0;
      st_reg.state       <= ST_IDLE;
      st_reg.grant_n     <= 1'b1;
      st_reg.done_n      <= 1'b1;
      st_reg.prev_sel_n  <= 1'b1;
      st_reg.prev_strb_n <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign io_grant_n_o   = st_reg.grant_n;
  assign cycle_done_n_o = st_reg.done_n;
  assign host_data_o    = st_reg.data;
  assign host_data_oe_o = st_reg.oe;
  assign ram_rd_o       = st_reg.ram_rd;
  assign ram_addr_o     = st_reg.addr[RAM_AW-1:0];
  assign reg_rd_o       = st_reg.reg_rd;
  assign reg_addr_o     = st_reg.addr[`HBRP_REG_AW-1:0];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_q);

  sequence s_req_free;
    ce_i && st_reg.state == ST_IDLE && strb_low && sel_low && cfg_ok && !pin.late
    && !ram_busy_i;
  endsequence

  sequence s_grant_fall;
    $fell(io_grant_n_o);
  endsequence

  a_grant_start: assert property (s_req_free |=> !io_grant_n_o)
    else $error("grant did not fall on a free request");

  a_busy_holds: assert property (s_grant_fall |-> $past(!ram_busy_i && ce_i))
    else $error("grant fell while RAM was busy");

  a_ram_ready: assert property ($fell(cycle_done_n_o) && st_reg.ctrl_mem
      |-> $past(st_reg.age) == `HBRP_AGE_W'(`HBRP_RAM_DONE_CYC - 1 + st_reg.extra))
    else $error("RAM read ready at wrong time");

  a_reg_ready: assert property ($fell(cycle_done_n_o) && !st_reg.ctrl_mem
      |-> $past(st_reg.age) == `HBRP_AGE_W'(`HBRP_REG_DONE_CYC - 1 + st_reg.extra))
    else $error("register read ready at wrong time");

  a_late_drop: assert property (ce_i && st_reg.state == ST_SEL && pin.sel_n
      |=> io_grant_n_o && st_reg.state == ST_HIGH)
    else $error("late select high still started a transfer");

  a_data_first: assert property ($fell(cycle_done_n_o) && st_reg.ctrl_rd && !(pin.hide
      && !st_reg.ctrl_mem && in_hidden(st_reg.addr[4:0])) |-> host_data_oe_o)
    else $error("data not driven when ready fell");

  a_strobe_end: assert property (ce_i && st_reg.state == ST_DONE && !strb_low
      |=> io_grant_n_o && cycle_done_n_o && !host_data_oe_o)
    else $error("cycle not released after strobe rise");

  a_addr_latch: assert property (ce_i && st_reg.state == ST_GRANT && strb_low
      && st_reg.age == `HBRP_AGE_W'(st_reg.extra) |=> st_reg.addr == $past(pin.addr))
    else $error("address not latched at the expected edge");

  a_hide_regs: assert property (pin.hide && !st_reg.ctrl_mem && st_reg.state == ST_DONE
      && in_hidden(st_reg.addr[4:0]) |-> !host_data_oe_o)
    else $error("data driven for a hidden register");

  a_ctrl_latch: assert property (ce_i && st_reg.state == ST_GRANT && st_reg.age == '0
      && strb_low |=> st_reg.ctrl_mem == $past(pin.mem_reg))
    else $error("control not latched after grant");

endmodule

/* File: verif/hbrp_host_model.sv */
// Host processor model driving the select, strobe, control and address pins
module hbrp_host_model (
  // Clock
  input  wire logic        clk_i,
  // Host pins
  output logic             sel_n_o,
  output logic             strb_n_o,
  output logic             mem_reg_o,
  output logic             rd_wr_o,
  output logic [15:0]      addr_o,
  // Device answer
  input  wire logic        grant_n_i,
  input  wire logic        done_n_i,
  input  wire logic [15:0] data_i,
  input  wire logic        oe_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sel_n_o   = 1'b1;
    strb_n_o  = 1'b1;
    mem_reg_o = 1'b0;
    rd_wr_o   = 1'b0;
    addr_o    = 16'h0000;
  end

  // ****************************************************************
  // One host cycle: strobe, wait grant, wait ready, strobe high
  // ****************************************************************
  task automatic read_cycle(input logic mem, input logic rw, input logic [15:0] a,
                            input int lag, input logic sel_on, input logic chg,
                            output logic granted, output int n, output logic [15:0] d,
                            output logic oe, output logic rel);
    int   i;
    logic seen;
    granted = 1'b0;
    seen    = 1'b0;
    rel     = 1'b0;
    n       = 0;
    d       = 16'h0000;
    oe      = 1'b0;
    @(posedge clk_i);
    mem_reg_o <= mem;
    rd_wr_o   <= rw;
    addr_o    <= a;
    strb_n_o  <= 1'b0;
    if (lag == 0)
      sel_n_o <= ~sel_on;
    for (i = 0; i < 200 && !granted; i++)
    begin
      @(posedge clk_i);
      if (i + 1 == lag)
        sel_n_o <= ~sel_on;
      #1;
      granted = (grant_n_i === 1'b0);
    end
    while (granted && !seen && n < 100)
    begin
      @(posedge clk_i);
      n++;
      if (n == 1)
        sel_n_o <= 1'b1;
      if (n == 3 && chg)
      begin
        addr_o    <= ~a;
        mem_reg_o <= ~mem;
      end
      #1;
      seen = (done_n_i === 1'b0);
      d    = data_i;
      oe   = oe_i;
    end
    @(posedge clk_i);
    strb_n_o <= 1'b1;
    sel_n_o  <= 1'b1;
    for (i = 0; i < 8 && !rel; i++)
    begin
      @(posedge clk_i);
      #1;
      rel = (grant_n_i === 1'b1) && (done_n_i === 1'b1) && (oe_i === 1'b0);
    end
    // Released lines show the inverse of the last value
    @(posedge clk_i);
    addr_o    <= ~addr_o;
    mem_reg_o <= ~mem_reg_o;
    rd_wr_o   <= ~rw;
    @(posedge clk_i);
  endtask
endmodule

/* File: verif/hbrp_port_tb_top.sv */
// Self-checking bench of the host read port
`include "hbrp_cfg.svh"
module hbrp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        pol = 1'b1;
  logic        late = 1'b0;
  logic        hide = 1'b0;
  logic        bstyle = `HBRP_BUS_STYLE_REQ;
  logic        width = `HBRP_WIDTH_REQ;
  logic        zwait = `HBRP_ZWAIT_REQ;
  logic        ram_busy = 1'b0;
  logic        ce = 1'b1;
  logic        sel_n, strb_n, mem_reg, rd_wr, grant_n, done_n, oe, ram_rd, reg_rd;
  logic [15:0] addr, data, ram_data, reg_data;
  logic [11:0] ram_addr;
  logic [4:0]  reg_addr;
  int          n_errors = 0;
  int          tests_run = 0;

  localparam int n_ram = `HBRP_RAM_DONE_CYC;

  always #5 clk_i = ~clk_i;

  hbrp_host_model host_u (.clk_i(clk_i), .sel_n_o(sel_n), .strb_n_o(strb_n),
    .mem_reg_o(mem_reg), .rd_wr_o(rd_wr), .addr_o(addr), .grant_n_i(grant_n),
    .done_n_i(done_n), .data_i(data), .oe_i(oe));

  hbrp_port #(.RAM_AW(12)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .host_sel_n_i(sel_n), .host_strobe_n_i(strb_n), .host_mem_reg_i(mem_reg),
    .host_rd_wr_i(rd_wr), .host_addr_i(addr), .polarity_strap_i(pol),
    .late_sel_strap_i(late), .hide_regs_strap_i(hide), .bus_style_strap_i(bstyle),
    .width_strap_i(width), .zero_wait_strap_i(zwait), .io_grant_n_o(grant_n),
    .cycle_done_n_o(done_n), .host_data_o(data), .host_data_oe_o(oe),
    .ram_busy_i(ram_busy), .ram_rd_o(ram_rd), .ram_addr_o(ram_addr),
    .ram_rd_data_i(ram_data), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
    .reg_rd_data_i(reg_data));

  // Internal RAM and registers answer one cycle after the pulse only
  always @(posedge clk_i)
  begin
    ram_data <= ram_rd ? {4'ha, ram_addr} : ~ram_data;
    reg_data <= reg_rd ? {11'h6c0, reg_addr} : ~reg_data;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run(input logic mem, input logic rw, input logic [15:0] a, input int lag,
                     input logic sel_on, input logic chg, input logic exp_g,
                     input int exp_n, input logic exp_oe, input logic [15:0] exp_d);
    logic        g, o, rel;
    int          n;
    logic [15:0] d;
    host_u.read_cycle(mem, rw, a, lag, sel_on, chg, g, n, d, o, rel);
    check(g, exp_g);
    check(rel, 1'b1);
    if (exp_g)
    begin
      check(n, exp_n);
      check(o, exp_oe);
    end
    if (exp_g && exp_oe)
      check(d, exp_d);
  endtask

  task automatic straps(input logic p, input logic l, input logic h, input logic b);
    @(posedge clk_i);
    pol    <= p;
    late   <= l;
    hide   <= h;
    bstyle <= b;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_ram_reg;
    straps(1'b1, 1'b0, 1'b0, 1'b0);
    run(1'b1, 1'b1, 16'hf123, 0, 1'b1, 1'b0, 1'b1, `HBRP_RAM_DONE_CYC, 1'b1, 16'ha123);
    run(1'b0, 1'b1, 16'h0ff5, 0, 1'b1, 1'b0, 1'b1, `HBRP_REG_DONE_CYC, 1'b1, 16'hd815);
  endtask

  task automatic t_polarity;
    straps(1'b0, 1'b0, 1'b0, 1'b0);
    run(1'b1, 1'b0, 16'h0abc, 0, 1'b1, 1'b0, 1'b1, `HBRP_RAM_DONE_CYC, 1'b1, 16'haabc);
    run(1'b1, 1'b1, 16'h0abc, 0, 1'b1, 1'b0, 1'b1, `HBRP_RAM_DONE_CYC, 1'b0, 16'h0000);
  endtask

  task automatic t_hidden;
    straps(1'b1, 1'b0, 1'b1, 1'b0);
    run(1'b0, 1'b1, 16'h0018, 0, 1'b1, 1'b0, 1'b1, `HBRP_REG_DONE_CYC, 1'b0, 16'h0000);
    run(1'b0, 1'b1, 16'h001f, 0, 1'b1, 1'b0, 1'b1, `HBRP_REG_DONE_CYC, 1'b0, 16'h0000);
    run(1'b0, 1'b1, 16'h0017, 0, 1'b1, 1'b0, 1'b1, `HBRP_REG_DONE_CYC, 1'b1, 16'hd817);
    straps(1'b1, 1'b0, 1'b0, 1'b0);
    run(1'b0, 1'b1, 16'h001a, 0, 1'b1, 1'b0, 1'b1, `HBRP_REG_DONE_CYC, 1'b1, 16'hd81a);
  endtask

  task automatic t_busy;
    logic bad;
    bad = 1'b0;
    @(posedge clk_i);
    ram_busy <= 1'b1;
    fork
      run(1'b1, 1'b1, 16'h0321, 0, 1'b1, 1'b0, 1'b1, `HBRP_RAM_DONE_CYC, 1'b1, 16'ha321);
      begin
        repeat (30) @(posedge clk_i) #1 bad = bad | (grant_n !== 1'b1);
        @(posedge clk_i);
        ram_busy <= 1'b0;
      end
    join
    check(bad, 1'b0);
  endtask

  // Clock enable low in mid-cycle stretches the ready delay by the frozen edges
  task automatic t_freeze;
    fork
      run(1'b1, 1'b1, 16'h0654, 0, 1'b1, 1'b0, 1'b1, n_ram + 10, 1'b1, 16'ha654);
      begin
        repeat (12) @(posedge clk_i);
        ce <= 1'b0;
        repeat (10) @(posedge clk_i);
        ce <= 1'b1;
      end
    join
  endtask

  task automatic t_latch_skew;
    run(1'b1, 1'b1, 16'h0456, 0, 1'b1, 1'b1, 1'b1, n_ram, 1'b1, 16'ha456);
    run(1'b1, 1'b1, 16'h0789, 1, 1'b1, 1'b1, 1'b1, n_ram + 1, 1'b1, 16'ha789);
  endtask

  task automatic t_late_straps;
    straps(1'b1, 1'b1, 1'b0, 1'b0);
    run(1'b1, 1'b1, 16'h0111, 1, 1'b1, 1'b0, 1'b1, `HBRP_RAM_DONE_CYC, 1'b1, 16'ha111);
    run(1'b1, 1'b1, 16'h0111, 0, 1'b0, 1'b0, 1'b0, 0, 1'b0, 16'h0000);
    straps(1'b1, 1'b0, 1'b0, 1'b1);
    run(1'b1, 1'b1, 16'h0222, 0, 1'b1, 1'b0, 1'b0, 0, 1'b0, 16'h0000);
    straps(1'b1, 1'b0, 1'b0, 1'b0);
    run(1'b0, 1'b1, 16'h0003, 0, 1'b1, 1'b0, 1'b1, `HBRP_REG_DONE_CYC, 1'b1, 16'hd803);
  endtask

  // ****************************************************************
  // Verdict and main sequence
  // ****************************************************************
  task automatic results;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #900us;
    n_errors++;
    results();
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_ram_reg();
    t_polarity();
    t_hidden();
    t_busy();
    t_freeze();
    t_latch_skew();
    t_late_straps();
    results();
  end
endmodule
